// ==== core/gpb_port.sv ====
// eight-bit bidirectional port with pull-ups, analog select and change interrupt
`timescale 1ns/10ps
module gpb_port
    import gpb_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // software side
    input wire gpb_req_s REQ,
    output gpb_rdata_s RDATA,
    // configuration straps
    input wire logic ANALOG_DEFAULT_CFG,
    input wire logic CAPTURE_PIN_SELECT_CFG,
    // power state
    input wire logic LOW_POWER_MODE,
    output logic WAKE_REQ,
    // change interrupt and pull-up disable
    output logic PIN_CHANGE_FLAG,
    output logic PULLUP_DISABLE_N,
    // pins
    input wire logic [GPB_WIDTH-1:0] PIN_IN,
    output logic [GPB_WIDTH-1:0] PIN_OUT,
    output logic [GPB_WIDTH-1:0] PIN_OE,
    output logic [GPB_WIDTH-1:0] PIN_PULLUP,
    // shared functions
    input wire logic CCP_OUT,
    input wire logic CCP_OUT_EN,
    output logic CCP_CAPTURE_IN,
    input wire logic PWM_FAULT_EN,
    output logic PWM_FAULT_IN,
    output logic EXT_IRQ_ZERO,
    output logic EXT_IRQ_ONE,
    output logic [GPB_ANA_PINS-1:0] ANALOG_SEL,
    output logic ANALOG_CH_TWELVE_SEL,
    output logic ANALOG_CH_TEN_SEL
);

    // one-hot strap loader: let the synchroniser fill, take the straps once, then run
    typedef enum logic [2:0] {
        st_fill = 3'b001,
        st_load = 3'b010,
        st_run = 3'b100
    } gpb_strap_e;

    logic [GPB_WIDTH-1:0] direction_reg_ff;
    logic [GPB_WIDTH-1:0] output_latch_reg_ff;
    logic [GPB_ANA_PINS-1:0] analog_ff;
    logic pullup_disable_n_ff;
    logic pin_change_flag_ff;
    logic [GPB_CHG_HI:GPB_CHG_LO] cmp_copy_ff;
    logic [1:0] strap_cnt_ff;
    gpb_strap_e strap_state_ff;
    logic strap_load;
    logic ccp_sel_ff;
    logic [GPB_WIDTH-1:0] pin_sync;
    logic [1:0] strap_sync;
    logic [GPB_WIDTH-1:0] din;
    logic [GPB_CHG_HI:GPB_CHG_LO] mismatch;
    logic any_mismatch;
    logic rd_refresh;
    logic wr_refresh;
    logic refresh;
    logic flag_set;
    logic flag_clear;
    logic [GPB_WIDTH-1:0] nxt_latch;
    logic [GPB_WIDTH-1:0] pin_drive;
    logic [GPB_WIDTH-1:0] rd_port_ff;
    logic [GPB_WIDTH-1:0] rd_latch_ff;
    logic [GPB_WIDTH-1:0] rd_dir_ff;
    logic [GPB_WIDTH-1:0] rd_analog_ff;
    logic [GPB_WIDTH-1:0] rd_ictl_ff;
    logic [GPB_WIDTH-1:0] rd_ictl2_ff;
    logic pwm_fault_ff;
    logic ccp_capture_ff;

    // pins and straps come from outside the clock domain
    gpb_sync #(.W(GPB_WIDTH)) u_pin_sync (
        .CLK(CLK),
        .RST(RST),
        .D(PIN_IN),
        .Q(pin_sync)
    );

    gpb_sync #(.W(2)) u_strap_sync (
        .CLK(CLK),
        .RST(RST),
        .D({CAPTURE_PIN_SELECT_CFG, ANALOG_DEFAULT_CFG}),
        .Q(strap_sync)
    );

    // straps are sampled once, after the synchroniser has filled
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            strap_cnt_ff <= 2'h0;
            strap_state_ff <= st_fill;
        end else begin
            unique case (strap_state_ff)
                st_fill: begin
                    strap_cnt_ff <= strap_cnt_ff + 2'h1;
                    if (strap_cnt_ff == GPB_STRAP_WAIT - 2'h1) begin
                        strap_state_ff <= st_load;
                    end
                end
                st_load: begin
                    strap_state_ff <= st_run;
                end
                st_run: begin
                    strap_state_ff <= st_run;
                end
            endcase
        end
    end

    // a strap moved after the load is ignored until the next reset, like a fuse
    assign strap_load = (strap_state_ff == st_load);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ccp_sel_ff <= 1'b0;
        end else if (strap_load) begin
            ccp_sel_ff <= ~strap_sync[1];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            analog_ff <= GPB_ANA_ON;
        end else if (strap_load) begin
            analog_ff <= strap_sync[0] ? GPB_ANA_ON : GPB_ANA_OFF;
        end else if (REQ.analog_wr) begin
            analog_ff <= REQ.wdata[GPB_ANA_PINS-1:0];
        end
    end

    // direction per pin, inputs after reset
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            direction_reg_ff <= GPB_DIR_RST;
        end else if (REQ.dir_wr) begin
            direction_reg_ff <= REQ.wdata;
        end
    end

    // port write loads latch as well
    always_comb begin
        nxt_latch = output_latch_reg_ff;
        if (REQ.port_wr || REQ.latch_wr) begin
            nxt_latch = REQ.wdata;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            output_latch_reg_ff <= GPB_LAT_RST;
        end else begin
            output_latch_reg_ff <= nxt_latch;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pullup_disable_n_ff <= GPB_PULLUP_DIS_N_RST;
        end else if (REQ.ictl2_wr) begin
            pullup_disable_n_ff <= REQ.wdata[GPB_PULLUP_BIT];
        end
    end

    // per pin drive, pull-up and digital input
    genvar gi;
    generate
        for (gi = 0; gi < GPB_WIDTH; gi++) begin : g_pin
            // capture unit overrides latch on its pin
            if (gi == GPB_CCP_PIN) begin : g_ccp
                assign pin_drive[gi] = (ccp_sel_ff && CCP_OUT_EN) ? CCP_OUT : output_latch_reg_ff[gi];
            end else begin : g_lat
                assign pin_drive[gi] = output_latch_reg_ff[gi];
            end
            assign PIN_OE[gi] = ~direction_reg_ff[gi];
            assign PIN_OUT[gi] = pin_drive[gi];
            assign PIN_PULLUP[gi] = ~pullup_disable_n_ff & direction_reg_ff[gi];
            if (gi < GPB_ANA_PINS) begin : g_ana
                assign din[gi] = analog_ff[gi] ? 1'b0 : pin_sync[gi];
            end else begin : g_dig
                assign din[gi] = pin_sync[gi];
            end
        end
    endgenerate

    // access of the port refreshes the copy, except the memory-move write
    assign rd_refresh = REQ.port_rd;
    // a memory-move write into the port leaves a stale copy, so the flag keeps coming back
    assign wr_refresh = REQ.port_wr & ~REQ.mem_move;
    assign refresh = rd_refresh | wr_refresh;

    // every port read refreshes, so a read ends a standing mismatch and lets the flag clear
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cmp_copy_ff <= '0;
        end else if (refresh) begin
            cmp_copy_ff <= din[GPB_CHG_HI:GPB_CHG_LO];
        end
    end

    generate
        for (gi = GPB_CHG_LO; gi <= GPB_CHG_HI; gi++) begin : g_chg
            assign mismatch[gi] = direction_reg_ff[gi] & (din[gi] ^ cmp_copy_ff[gi]);
        end
    endgenerate

    assign any_mismatch = |mismatch;

    // a standing mismatch sets again, winning over clear
    assign flag_set = any_mismatch;
    assign flag_clear = REQ.flag_clr & ~any_mismatch;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pin_change_flag_ff <= 1'b0;
        end else if (flag_set) begin
            pin_change_flag_ff <= 1'b1;
        end else if (flag_clear) begin
            pin_change_flag_ff <= 1'b0;
        end
    end

    // read data is registered, one cycle behind the state it shows
    // port reads pin levels, with analog-selected pins reading as zero
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_port_ff <= '0;
        end else begin
            rd_port_ff <= din;
        end
    end

    // latch reads the latch, not pins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_latch_ff <= '0;
        end else begin
            rd_latch_ff <= output_latch_reg_ff;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_dir_ff <= '0;
        end else begin
            rd_dir_ff <= direction_reg_ff;
        end
    end

    // analog selection in the low five bits
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_analog_ff <= '0;
        end else begin
            rd_analog_ff <= {3'h0, analog_ff};
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_ictl_ff <= '0;
        end else begin
            rd_ictl_ff <= {7'h00, pin_change_flag_ff};
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_ictl2_ff <= '0;
        end else begin
            rd_ictl2_ff <= {pullup_disable_n_ff, 7'h00};
        end
    end

    assign RDATA = '{
        port: rd_port_ff,
        latch: rd_latch_ff,
        dir: rd_dir_ff,
        analog: rd_analog_ff,
        ictl: rd_ictl_ff,
        ictl2: rd_ictl2_ff
    };

    // fault input passes only while enabled
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pwm_fault_ff <= 1'b0;
        end else begin
            pwm_fault_ff <= PWM_FAULT_EN & pin_sync[0];
        end
    end

    // capture input only while the pin is routed to the unit
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ccp_capture_ff <= 1'b0;
        end else begin
            ccp_capture_ff <= ccp_sel_ff & pin_sync[GPB_CCP_PIN];
        end
    end

    assign WAKE_REQ = pin_change_flag_ff & LOW_POWER_MODE;
    assign PIN_CHANGE_FLAG = pin_change_flag_ff;
    assign PULLUP_DISABLE_N = pullup_disable_n_ff;

    // shared inputs of pins zero and one, analog selects, and the capture input of pin three
    assign EXT_IRQ_ZERO = pin_sync[0];
    assign EXT_IRQ_ONE = pin_sync[1];
    assign PWM_FAULT_IN = pwm_fault_ff;
    assign ANALOG_SEL = analog_ff;
    assign ANALOG_CH_TWELVE_SEL = analog_ff[0];
    assign ANALOG_CH_TEN_SEL = analog_ff[1];
    assign CCP_CAPTURE_IN = ccp_capture_ff;

endmodule

// ==== core/gpb_pkg.sv ====
// package for the bidirectional port with change detection
package gpb_pkg;

    localparam int GPB_WIDTH = 8;
    localparam int GPB_ANA_PINS = 5;
    localparam int GPB_CHG_LO = 4;
    localparam int GPB_CHG_HI = 7;
    localparam int GPB_CCP_PIN = 3;
    localparam int GPB_SYNC_STAGES = 2;

    // field positions in the two interrupt control registers
    localparam int GPB_PULLUP_BIT = 7;
    localparam int GPB_FLAG_BIT = 0;

    // values after reset
    localparam logic [7:0] GPB_DIR_RST = 8'hff;
    localparam logic [7:0] GPB_LAT_RST = 8'h00;
    localparam logic [4:0] GPB_ANA_ON = 5'h1f;
    localparam logic [4:0] GPB_ANA_OFF = 5'h00;
    localparam logic GPB_PULLUP_DIS_N_RST = 1'b1;

    // cycles after reset release before the configuration straps are trusted
    localparam logic [1:0] GPB_STRAP_WAIT = 2'h2;

    typedef struct packed {
        logic port_rd;
        logic port_wr;
        logic mem_move;
        logic latch_wr;
        logic dir_wr;
        logic analog_wr;
        logic ictl2_wr;
        logic flag_clr;
        logic [7:0] wdata;
    } gpb_req_s;

    typedef struct packed {
        logic [7:0] port;
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] analog;
        logic [7:0] ictl;
        logic [7:0] ictl2;
    } gpb_rdata_s;

endpackage

// ==== core/gpb_sync.sv ====
// two-stage synchroniser for levels arriving from outside the clock domain
`timescale 1ns/10ps
module gpb_sync
    import gpb_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // data
    input wire logic [W-1:0] D,
    output logic [W-1:0] Q
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // first stage is read only by the second
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= D;
            q_ff <= meta_ff;
        end
    end

    assign Q = q_ff;

endmodule

// ==== testbench/gpb_pin_model.sv ====
// board-side model of the eight port pins
`timescale 1ns/10ps
module gpb_pin_model
    import gpb_pkg::*;
(
    // clock for the floating pattern
    input wire logic clk,
    // device side
    input wire logic [GPB_WIDTH-1:0] pin_out,
    input wire logic [GPB_WIDTH-1:0] pin_oe,
    input wire logic [GPB_WIDTH-1:0] pin_pullup,
    // board side
    input wire logic [GPB_WIDTH-1:0] ext_val,
    input wire logic [GPB_WIDTH-1:0] ext_en,
    output logic [GPB_WIDTH-1:0] pin_in
);
    // an undriven pin without pull-up wanders, so nothing may rely on it
    logic [GPB_WIDTH-1:0] float_ff = 8'h55;
    always @(posedge clk) float_ff <= ~float_ff;
    always_comb begin
        for (int i = 0; i < GPB_WIDTH; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pin_pullup[i]) pin_in[i] = 1'b1;
            else pin_in[i] = float_ff[i];
        end
    end
endmodule

// ==== testbench/gpb_port_monitor.sv ====
// concurrent checks on the port block outputs
`timescale 1ns/10ps
module gpb_port_monitor
    import gpb_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // software side
    input wire gpb_req_s REQ,
    input wire gpb_rdata_s RDATA,
    // status
    input wire logic LOW_POWER_MODE,
    input wire logic WAKE_REQ,
    input wire logic PIN_CHANGE_FLAG,
    input wire logic PULLUP_DISABLE_N,
    // pins
    input wire logic [GPB_WIDTH-1:0] PIN_OUT,
    input wire logic [GPB_WIDTH-1:0] PIN_OE,
    input wire logic [GPB_WIDTH-1:0] PIN_PULLUP
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_pull_global: assert property (PIN_PULLUP == (PULLUP_DISABLE_N ? 8'h00 : ~PIN_OE))
        else $error("pull-up pattern wrong");
    a_dir_drive: assert property (REQ.dir_wr |=> PIN_OE == ~$past(REQ.wdata))
        else $error("drive enable wrong");
    // pin three may carry the capture unit, so it is masked here
    a_latch_drive: assert property ((REQ.latch_wr || REQ.port_wr) |=> (PIN_OUT & 8'hf7) == ($past(REQ.wdata) & 8'hf7))
        else $error("pin output wrong");
    a_latch_read: assert property (REQ.latch_wr |-> ##2 RDATA.latch == $past(REQ.wdata, 2))
        else $error("latch readback wrong");
    a_wake_req: assert property (WAKE_REQ == (PIN_CHANGE_FLAG && LOW_POWER_MODE))
        else $error("wake request wrong");
    a_reset_pull: assert property ($fell(RST) |-> PIN_PULLUP == 8'h00 && PULLUP_DISABLE_N)
        else $error("pull-ups on after reset");
    a_flag_hold: assert property (PIN_CHANGE_FLAG && !REQ.flag_clr |=> PIN_CHANGE_FLAG)
        else $error("flag dropped uncleared");
    a_flag_view: assert property (RDATA.ictl == {7'h00, $past(PIN_CHANGE_FLAG)})
        else $error("flag readback wrong");
endmodule
bind gpb_port gpb_port_monitor u_mon (.CLK(CLK), .RST(RST), .REQ(REQ), .RDATA(RDATA),
    .LOW_POWER_MODE(LOW_POWER_MODE), .WAKE_REQ(WAKE_REQ), .PIN_CHANGE_FLAG(PIN_CHANGE_FLAG),
    .PULLUP_DISABLE_N(PULLUP_DISABLE_N), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP));

// ==== testbench/gpb_port_bench.sv ====
// self-checking bench for the bidirectional port with change detection
`timescale 1ns/10ps
module gpb_port_bench;
    import gpb_pkg::*;
    localparam logic [7:0] S_RD = 8'h80, S_PW = 8'h40, S_MM = 8'h20, S_LW = 8'h10;
    localparam logic [7:0] S_DW = 8'h08, S_AW = 8'h04, S_IW = 8'h02, S_FC = 8'h01;
    logic clk = 1'b0, rst = 1'b1, ana_cfg = 1'b1, ccp_cfg = 1'b1, lpm = 1'b0;
    logic ccp_out = 1'b0, ccp_en = 1'b0, flt_en = 1'b0;
    logic wake, flag, pud_n, ccp_cap, flt_in, irq0, irq1, ch12, ch10;
    logic [7:0] ext_val = 8'hff, ext_en = 8'hff, pin_in, pin_out, pin_oe, pin_pu;
    logic [4:0] ana_sel;
    gpb_req_s req = '0;
    gpb_rdata_s rdata;
    int miscompares = 0, checks = 0;
    gpb_port u_dut (.CLK(clk), .RST(rst), .REQ(req), .RDATA(rdata), .ANALOG_DEFAULT_CFG(ana_cfg),
        .CAPTURE_PIN_SELECT_CFG(ccp_cfg), .LOW_POWER_MODE(lpm), .WAKE_REQ(wake), .PIN_CHANGE_FLAG(flag),
        .PULLUP_DISABLE_N(pud_n), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_PULLUP(pin_pu),
        .CCP_OUT(ccp_out), .CCP_OUT_EN(ccp_en), .CCP_CAPTURE_IN(ccp_cap), .PWM_FAULT_EN(flt_en),
        .PWM_FAULT_IN(flt_in), .EXT_IRQ_ZERO(irq0), .EXT_IRQ_ONE(irq1), .ANALOG_SEL(ana_sel),
        .ANALOG_CH_TWELVE_SEL(ch12), .ANALOG_CH_TEN_SEL(ch10));
    gpb_pin_model u_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu),
        .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
    initial forever #5 clk = ~clk;
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr(input logic [7:0] s, input logic [7:0] d);
        @(posedge clk);
        #1 req = {s, d};
        @(posedge clk);
        #1 req = '0;
    endtask
    task rst_dut(input logic a, input logic c);
        ana_cfg = a;
        ccp_cfg = c;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        idle(8);
    endtask
    task t_reset;
        rst_dut(1'b1, 1'b1);
        cmp(rdata.dir, 8'hff);
        cmp(rdata.latch, 8'h00);
        cmp(rdata.analog, 8'h1f);
        cmp(rdata.port, 8'he0);
        cmp(pin_pu, 8'h00);
        rst_dut(1'b0, 1'b0);
        cmp(rdata.analog, 8'h00);
        cmp(rdata.port, 8'hff);
    endtask
    task t_drive;
        ext_val = 8'h00;
        wr(S_LW, 8'h5a);
        wr(S_DW, 8'h0f);
        idle(4);
        cmp(pin_oe, 8'hf0);
        cmp(pin_out & 8'hf7, 8'h52);
        cmp(rdata.latch, 8'h5a);
        cmp(rdata.port, 8'h50);
        wr(S_PW, 8'ha5);
        idle(4);
        cmp(rdata.latch, 8'ha5);
        cmp(rdata.port, 8'ha0);
    endtask
    task t_pullup;
        ext_en = 8'h00;
        wr(S_IW, 8'h00);
        idle(4);
        cmp(8'(pud_n), 8'h00);
        cmp(pin_pu, 8'h0f);
        cmp(rdata.port, 8'haf);
        cmp(rdata.ictl2, 8'h00);
        wr(S_IW, 8'h80);
        ext_en = 8'hff;
        cmp(pin_pu, 8'h00);
    endtask
    task t_change;
        wr(S_DW, 8'h7f);
        idle(3);
        wr(S_RD, 8'h00);
        wr(S_FC, 8'h00);
        idle(2);
        cmp(8'(flag), 8'h00);
        ext_val = 8'h40;
        lpm = 1'b1;
        idle(5);
        cmp(8'(flag), 8'h01);
        cmp(8'(wake), 8'h01);
        wr(S_FC, 8'h00);
        idle(2);
        cmp(8'(flag), 8'h01);
        // software clearing sequence, memory move does not count
        wr(S_PW | S_MM, 8'h80);
        wr(S_FC, 8'h00);
        idle(2);
        cmp(8'(flag), 8'h01);
        wr(S_RD, 8'h00);
        wr(S_FC, 8'h00);
        idle(2);
        cmp(8'(flag), 8'h00);
        lpm = 1'b0;
        wr(S_LW, 8'h00);
        ext_val = 8'h4f;
        idle(5);
        cmp(8'(flag), 8'h00);
    endtask
    task t_shared;
        ccp_en = 1'b1;
        ccp_out = 1'b1;
        ext_val = 8'h03;
        flt_en = 1'b1;
        wr(S_DW, 8'hf7);
        idle(4);
        cmp(8'(pin_out[3]), 8'h01);
        cmp(8'(ccp_cap), 8'h01);
        cmp({5'h00, flt_in, irq1, irq0}, 8'h07);
        ext_val = 8'h00;
        wr(S_AW, 8'h03);
        idle(4);
        cmp({5'h00, flt_in, irq1, irq0}, 8'h00);
        cmp({1'b0, ch10, ch12, ana_sel}, 8'h63);
    endtask
    task end_sim;
        if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #50000;
        miscompares++;
        end_sim;
    end
    initial begin
        t_reset;
        t_drive;
        t_pullup;
        t_change;
        t_shared;
        end_sim;
    end
endmodule
